//--- include/cps_consts.svh
// Timing counts, widths and field positions for the card coupler serial port
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

// ==========================================
// Byte layout
`define CPS_BYTE_W 8
`define CPS_CNT_W 3
`define CPS_LAST_BIT 3'h7
`define CPS_ADDR_DONE 3'h2
`define CPS_MISO_START 3'h3
`define CPS_STAT_W 5
`define CPS_BANK_BIT 1'b0

// ==========================================
// Serial clock timing
`define CPS_CLK_NS 5
`define CPS_SCK_PERIOD_NS 125
`define CPS_HALF_CYC ((`CPS_SCK_PERIOD_NS / 2) / `CPS_CLK_NS)
`define CPS_TMR_W 4

// ==========================================
// Host buffer
`define CPS_FIFO_DEPTH 16

`endif

//--- include/cps_pkg.sv
// Types shared by both ends of the card coupler serial port
package cps_pkg;

   // ==========================================
   // Data types
   typedef logic [7:0] cps_byte_t;
   typedef logic [4:0] cps_stat_t;

   // ==========================================
   // Host sequencer states, Gray coded in the order listed
   typedef enum logic [2:0] {
      CPS_IDLE = 3'h0,
      CPS_SEL = 3'h1,
      CPS_LOW = 3'h3,
      CPS_HIGH = 3'h2,
      CPS_GAP = 3'h6,
      CPS_DESEL = 3'h7
   } cps_state_t;

endpackage

//--- include/cps_link_if.sv
// Serial link between host master and card coupler slave
`timescale 1ns/10ps
interface cps_link_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic miso;

   // Released line floats high through the pullup
   assign miso = miso_oe ? miso_o : 1'b1;

   modport device (
      input sck,
      input cs_n,
      input mosi,
      output miso_o,
      output miso_oe
   );

   modport host (
      output sck,
      output cs_n,
      output mosi,
      input miso
   );
endinterface

//--- rtl/cps_device.sv
// Card coupler serial slave: address decode, command latch, status readout
`timescale 1ns/10ps
`include "cps_consts.svh"

module cps_device (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Serial link
   cps_link_if.device link,
   // Address straps
   input wire logic address_strap_lo,
   input wire logic address_strap_hi,
   // User side
   input wire cps_pkg::cps_stat_t status_word,
   output cps_pkg::cps_byte_t command_byte_reg,
   output logic command_update
);
   import cps_pkg::*;

   // ==========================================
   // Address compare
   function automatic logic addr_ok(
      input logic [2:0] field,
      input logic hi,
      input logic lo
   );
      addr_ok = (field == {`CPS_BANK_BIT, hi, lo});
   endfunction

   // ==========================================
   // Input synchronisers
   logic [1:0] sck_sync;
   logic [1:0] cs_sync;
   logic [1:0] mosi_sync;
   logic [1:0] lo_sync;
   logic [1:0] hi_sync;
   logic sck_prev;
   logic cs_prev;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sck_sync <= 2'h0;
         cs_sync <= 2'h3;
         mosi_sync <= 2'h0;
         lo_sync <= 2'h3;
         hi_sync <= 2'h3;
         sck_prev <= 1'b0;
         cs_prev <= 1'b1;
      end else begin
         sck_sync <= {sck_sync[0], link.sck};
         cs_sync <= {cs_sync[0], link.cs_n};
         mosi_sync <= {mosi_sync[0], link.mosi};
         lo_sync <= {lo_sync[0], address_strap_lo};
         hi_sync <= {hi_sync[0], address_strap_hi};
         sck_prev <= sck_sync[1];
         cs_prev <= cs_sync[1];
      end
   end

   // ==========================================
   // Edge detection
   logic cs_high;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;

   always_comb begin
      cs_high = cs_sync[1];
      cs_fall = cs_prev & ~cs_sync[1];
      cs_rise = ~cs_prev & cs_sync[1];
      sck_rise = ~sck_prev & sck_sync[1];
      sck_fall = sck_prev & ~sck_sync[1];
   end

   // ==========================================
   // Frame state
   logic [7:0] shift;
   logic [`CPS_CNT_W-1:0] bit_cnt;
   logic match;
   logic [7:0] pend;
   logic pend_v;
   logic [4:0] stat_sh;
   logic miso_q;
   logic miso_oe_q;
   logic [7:0] cmd_q;
   logic upd_q;

   logic [7:0] next_shift;
   logic [`CPS_CNT_W-1:0] next_bit_cnt;
   logic next_match;
   logic [7:0] next_pend;
   logic next_pend_v;
   logic [4:0] next_stat_sh;
   logic next_miso_q;
   logic next_miso_oe_q;
   logic [7:0] next_cmd_q;
   logic next_upd_q;

   always_comb begin
      next_shift = shift;
      next_bit_cnt = bit_cnt;
      next_match = match;
      next_pend = pend;
      next_pend_v = pend_v;
      next_stat_sh = stat_sh;
      next_miso_q = miso_q;
      next_miso_oe_q = miso_oe_q;
      next_cmd_q = cmd_q;
      next_upd_q = 1'b0;
      if (cs_high) begin
         // Idle: line released, clock ignored
         next_miso_oe_q = 1'b0;
         if (cs_rise && pend_v) begin
            next_cmd_q = pend;
            next_upd_q = 1'b1;
         end
         if (cs_rise) begin
            next_pend_v = 1'b0;
         end
      end else if (cs_fall) begin
         next_shift = 8'h00;
         next_bit_cnt = 3'h0;
         next_match = 1'b0;
         next_pend_v = 1'b0;
         next_stat_sh = 5'h00;
         next_miso_oe_q = 1'b0;
      end else begin
         if (sck_rise) begin
            next_shift = {shift[6:0], mosi_sync[1]};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `CPS_ADDR_DONE) begin
               next_match = addr_ok(next_shift[2:0], hi_sync[1], lo_sync[1]);
            end
            if (bit_cnt == `CPS_LAST_BIT && match) begin
               next_pend = next_shift;
               next_pend_v = 1'b1;
            end
         end
         // Falling edges only: a clock parked high starts with a fall
         if (sck_fall) begin
            if (bit_cnt == `CPS_MISO_START && match) begin
               next_miso_q = status_word[4];
               next_stat_sh = {status_word[3:0], 1'b0};
               next_miso_oe_q = 1'b1;
            end else if (bit_cnt == 3'h0) begin
               next_miso_oe_q = 1'b0;
            end else if (miso_oe_q) begin
               next_miso_q = stat_sh[4];
               next_stat_sh = {stat_sh[3:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shift <= 8'h00;
         bit_cnt <= 3'h0;
         match <= 1'b0;
         pend <= 8'h00;
         pend_v <= 1'b0;
         stat_sh <= 5'h00;
         miso_q <= 1'b1;
         miso_oe_q <= 1'b0;
         cmd_q <= 8'h00;
         upd_q <= 1'b0;
      end else begin
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
         match <= next_match;
         pend <= next_pend;
         pend_v <= next_pend_v;
         stat_sh <= next_stat_sh;
         miso_q <= next_miso_q;
         miso_oe_q <= next_miso_oe_q;
         cmd_q <= next_cmd_q;
         upd_q <= next_upd_q;
      end
   end

   // ==========================================
   // Outputs
   // Command only leaves on the user side, never on MISO
   assign command_byte_reg = cmd_q;
   assign command_update = upd_q;

   // ==========================================
   // Link drive
   assign link.miso_o = miso_q;
   assign link.miso_oe = miso_oe_q;

endmodule

//--- rtl/cps_host.sv
// Host serial master with transmit FIFO for the card coupler port
`timescale 1ns/10ps
`include "cps_consts.svh"

// ==========================================
// Transmit FIFO
module cps_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic ready_q;
   logic next_ready_q;
   logic push;
   logic pop;

   // Ready comes from a flop
   always_comb begin
      in_ready = ready_q;
      out_valid = wr_ptr != rd_ptr;
      out_data = mem[rd_ptr[AW-1:0]];
      push = in_valid & ready_q;
      pop = out_valid & out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_ready_q = (next_wr_ptr - next_rd_ptr) != (AW+1)'(D);
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         ready_q <= 1'b1;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         ready_q <= next_ready_q;
      end
   end
endmodule

// ==========================================
// Serial master
module cps_host (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Serial link
   cps_link_if.host link,
   // Bytes to send
   input wire logic tx_valid,
   output logic tx_ready,
   input wire cps_pkg::cps_byte_t tx_data,
   // Bytes read back
   output logic rx_valid,
   output cps_pkg::cps_byte_t rx_data,
   output logic busy
);
   import cps_pkg::*;

   localparam logic [`CPS_TMR_W-1:0] HALF = `CPS_TMR_W'(`CPS_HALF_CYC - 1);

   logic f_valid;
   logic f_pop;
   cps_byte_t f_data;

   cps_fifo #(.W(`CPS_BYTE_W), .D(`CPS_FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data(tx_data),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   logic [1:0] miso_sync;
   cps_state_t st, next_st;
   logic [`CPS_TMR_W-1:0] tmr, next_tmr;
   logic [2:0] bit_cnt, next_bit_cnt;
   cps_byte_t sh, next_sh, rx, next_rx, rx_out, next_rx_out;
   logic sck, next_sck, cs_n, next_cs_n, mosi, next_mosi, rxv, next_rxv;
   logic bsy, next_bsy;

   // ==========================================
   // Sequencer
   always_comb begin
      next_st = st;
      next_tmr = (tmr == '0) ? HALF : tmr - 1'b1;
      next_bit_cnt = bit_cnt;
      next_sh = sh;
      next_rx = rx;
      next_rx_out = rx_out;
      next_sck = sck;
      next_cs_n = cs_n;
      next_mosi = mosi;
      next_rxv = 1'b0;
      f_pop = 1'b0;
      case (st)
         CPS_IDLE: begin
            next_tmr = HALF;
            if (f_valid) begin
               f_pop = 1'b1;
               next_sh = f_data;
               next_cs_n = 1'b0;
               next_bit_cnt = 3'h0;
               next_st = CPS_SEL;
            end
         end
         CPS_SEL, CPS_GAP: begin
            if (tmr == '0) begin
               next_mosi = sh[7];
               next_sh = {sh[6:0], 1'b0};
               next_st = CPS_LOW;
            end
         end
         CPS_LOW: begin
            if (tmr == '0) begin
               next_sck = 1'b1;
               next_rx = {rx[6:0], miso_sync[1]};
               next_st = CPS_HIGH;
            end
         end
         CPS_HIGH: begin
            if (tmr == '0) begin
               next_sck = 1'b0;
               if (bit_cnt == `CPS_LAST_BIT) begin
                  next_rxv = 1'b1;
                  next_rx_out = rx;
                  next_bit_cnt = 3'h0;
                  if (f_valid) begin
                     f_pop = 1'b1;
                     next_sh = f_data;
                     next_st = CPS_GAP;
                  end else begin
                     next_st = CPS_DESEL;
                  end
               end else begin
                  next_bit_cnt = bit_cnt + 3'h1;
                  next_mosi = sh[7];
                  next_sh = {sh[6:0], 1'b0};
                  next_st = CPS_LOW;
               end
            end
         end
         CPS_DESEL: begin
            if (tmr == '0) begin
               if (!cs_n) begin
                  next_cs_n = 1'b1;
               end else begin
                  next_st = CPS_IDLE;
               end
            end
         end
         default: begin
            next_st = CPS_IDLE;
         end
      endcase
      next_bsy = ~next_cs_n;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         miso_sync <= 2'h3;
         st <= CPS_IDLE;
         tmr <= '0;
         bit_cnt <= 3'h0;
         sh <= 8'h00;
         rx <= 8'h00;
         rx_out <= 8'h00;
         sck <= 1'b0;
         cs_n <= 1'b1;
         mosi <= 1'b0;
         rxv <= 1'b0;
         bsy <= 1'b0;
      end else begin
         miso_sync <= {miso_sync[0], link.miso};
         st <= next_st;
         tmr <= next_tmr;
         bit_cnt <= next_bit_cnt;
         sh <= next_sh;
         rx <= next_rx;
         rx_out <= next_rx_out;
         sck <= next_sck;
         cs_n <= next_cs_n;
         mosi <= next_mosi;
         rxv <= next_rxv;
         bsy <= next_bsy;
      end
   end

   assign link.sck = sck;
   assign link.cs_n = cs_n;
   assign link.mosi = mosi;
   assign rx_valid = rxv;
   assign rx_data = rx_out;
   assign busy = bsy;
endmodule

//--- tb/cps_link_properties.sv
// Timing properties of the serial link between host and device
`timescale 1ns/10ps
module cps_link_properties (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link lines
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic miso
);
   // ==========================================
   // Edge and phase counters
   logic sck_d, next_sck_d;
   logic [7:0] nrise, next_nrise;
   logic [4:0] hi_cnt, next_hi_cnt, lo_cnt, next_lo_cnt;
   always_comb begin
      next_sck_d = sck;
      next_nrise = cs_n ? 8'h00 : nrise + {7'h00, sck & ~sck_d};
      next_hi_cnt = sck ? hi_cnt + 5'h01 : 5'h00;
      next_lo_cnt = sck ? 5'h00 : lo_cnt + 5'h01;
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sck_d <= 1'b0;
         nrise <= 8'h00;
         hi_cnt <= 5'h00;
         lo_cnt <= 5'h00;
      end else begin
         sck_d <= next_sck_d;
         nrise <= next_nrise;
         hi_cnt <= next_hi_cnt;
         lo_cnt <= next_lo_cnt;
      end
   end

   // ==========================================
   // Properties
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_idle_quiet; cs_n [*6] |-> !miso_oe; endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("miso driven while deselected");
   property p_line_free; cs_n [*6] |-> miso; endproperty
   a_line_free: assert property (p_line_free) else $error("miso line not released");
   property p_sck_park; cs_n |-> !sck; endproperty
   a_sck_park: assert property (p_sck_park) else $error("clock moves while deselected");
   property p_fresh; $fell(cs_n) |-> (!miso_oe) [*8]; endproperty
   a_fresh: assert property (p_fresh) else $error("miso driven at frame start");
   property p_mosi_hold; sck && !cs_n |-> $stable(mosi); endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while clock high");
   property p_high_len; $fell(sck) |-> hi_cnt == 5'h0C; endproperty
   a_high_len: assert property (p_high_len) else $error("clock high phase wrong");
   property p_byte_gap; $rose(sck) && nrise != 8'h00 && nrise[2:0] == 3'h0 |-> lo_cnt >= 5'h12; endproperty
   a_byte_gap: assert property (p_byte_gap) else $error("gap between bytes too short");
   property p_oe_start; $rose(miso_oe) |-> nrise[2:0] == 3'h3 && !cs_n; endproperty
   a_oe_start: assert property (p_oe_start) else $error("miso enabled off the third bit");
   property p_oe_stop; $fell(sck) && nrise[2:0] == 3'h0 |-> ##[1:6] !miso_oe; endproperty
   a_oe_stop: assert property (p_oe_stop) else $error("miso kept after byte end");
   property p_miso_steady; sck && miso_oe && $past(miso_oe) |-> $stable(miso_o); endproperty
   a_miso_steady: assert property (p_miso_steady) else $error("miso moved while clock high");
   property p_whole_bytes; $rose(cs_n) |-> nrise[2:0] == 3'h0 && nrise != 8'h00; endproperty
   a_whole_bytes: assert property (p_whole_bytes) else $error("frame closed mid byte");
   c_multi: cover property ($rose(sck) && nrise == 8'h08);
   c_oe: cover property ($rose(miso_oe));
   c_close: cover property ($rose(cs_n));
endmodule

//--- tb/cps_tb_top.sv
// Bench joining host and device ends of the card coupler serial port
`timescale 1ns/10ps
module card_coupler_serial_slave_port_tb_top;
   import cps_pkg::*;
   logic clk_sys, rst_n, tx_valid, tx_ready, rx_valid, busy, upd, upd_b, s_lo, s_hi;
   cps_byte_t tx_data, rx_data, cmd, cmd_b;
   cps_stat_t stat;
   cps_byte_t rxq[$];
   int bad_count, checked, nupd, nupd_b;
   cps_link_if link();
   cps_link_if link_b();
   cps_host u_cps_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy));
   cps_device u_cps_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .address_strap_lo(s_lo),
      .address_strap_hi(s_hi), .status_word(stat), .command_byte_reg(cmd), .command_update(upd));
   cps_device u_cps_device_b (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_b), .address_strap_lo(s_lo),
      .address_strap_hi(s_hi), .status_word(stat), .command_byte_reg(cmd_b), .command_update(upd_b));
   cps_link_properties u_cps_link_properties (.clk_sys(clk_sys), .rst_n(rst_n), .sck(link.sck),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe), .miso(link.miso));

   // ==========================================
   // Clock and monitors
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
      if (upd === 1'b1) nupd++;
      if (upd_b === 1'b1) nupd_b++;
   end

   // ==========================================
   // Shared tasks
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic push(input cps_byte_t b);
      tx_valid <= 1'b1;
      tx_data <= b;
      do @(posedge clk_sys); while (tx_ready !== 1'b1);
   endtask
   task automatic wait_done;
      int n = 0;
      while (busy !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      while (busy !== 1'b0 && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
      if (busy !== 1'b0) bad_count++;
      repeat (10) @(posedge clk_sys);
   endtask
   task automatic half(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic frame_b(input cps_byte_t b, input int nb, input logic sel);
      link_b.cs_n <= ~sel;
      half(12);
      for (int i = 7; i > 7 - nb; i--) begin
         link_b.sck <= 1'b0;
         link_b.mosi <= b[i];
         half(12);
         link_b.sck <= 1'b1;
         half(13);
      end
      link_b.cs_n <= 1'b1;
      link_b.mosi <= ~link_b.mosi;
      half(12);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_addr_sweep;
      int u;
      for (int s = 0; s < 4; s++) begin
         s_lo <= s[0];
         s_hi <= s[1];
         stat <= {3'h5, s[1:0]};
         u = nupd;
         rxq.delete();
         repeat (6) @(posedge clk_sys);
         for (int a = 0; a < 8; a++) push({a[2:0], 5'h0A ^ {3'h0, a[1:0]}});
         tx_valid <= 1'b0;
         wait_done;
         cmp(cmd, {1'b0, s[1:0], 5'h0A ^ {3'h0, s[1:0]}});
         cmp(8'(nupd - u), 8'h01);
         cmp(8'(rxq.size()), 8'h08);
         cmp(rxq[s], {3'h7, 3'h5, s[1:0]});
         cmp(rxq[7], 8'hFF);
      end
      $display("address sweep done");
   endtask
   task automatic t_fill;
      int n = 0;
      logic [7:0] keep;
      keep = cmd;
      rxq.delete();
      tx_valid <= 1'b1;
      tx_data <= 8'hE5;
      do begin
         @(posedge clk_sys);
         if (tx_ready === 1'b1) n++;
      end while (tx_ready === 1'b1 && n < 40);
      tx_valid <= 1'b0;
      cmp(8'(n >= 16), 8'h01);
      wait_done;
      cmp(8'(rxq.size()), 8'(n));
      cmp(cmd, keep);
      $display("fill done");
   endtask
   task automatic t_direct;
      int u;
      u = nupd_b;
      s_lo <= 1'b1;
      s_hi <= 1'b0;
      frame_b(8'h35, 8, 1'b0);
      cmp(8'(nupd_b - u), 8'h00);
      frame_b(8'h35, 8, 1'b1);
      cmp(cmd_b, 8'h35);
      frame_b(8'h2A, 5, 1'b1);
      cmp(cmd_b, 8'h35);
      cmp(8'(nupd_b - u), 8'h01);
      frame_b(8'h21, 8, 1'b1);
      cmp(cmd_b, 8'h21);
      cmp({7'h00, link_b.miso_oe}, 8'h00);
      $display("direct frames done");
   endtask

   // ==========================================
   // Main sequence and watchdog
   initial begin
      rst_n = 1'b0;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      s_lo = 1'b0;
      s_hi = 1'b0;
      stat = 5'h00;
      link_b.sck = 1'b1;
      link_b.cs_n = 1'b1;
      link_b.mosi = 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      cmp(cmd, 8'h00);
      t_addr_sweep;
      t_fill;
      t_direct;
      report_and_stop;
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      report_and_stop;
   end
endmodule
